//--- dbg_pkg.sv
// Shared constants and carriers for the core breakpoint and trace debug block
package dbg_pkg;
    localparam int WORD_W = 32;
    localparam int IDX_W = 4;
    localparam int REG_CNT = 9;
    localparam int PC_CNT = 4;
    localparam int PST_W = 4;
    localparam logic [IDX_W-1:0] IDX_ADDR = 4'h0;
    localparam logic [IDX_W-1:0] IDX_ADDR_MASK = 4'h1;
    localparam logic [IDX_W-1:0] IDX_DATA = 4'h2;
    localparam logic [IDX_W-1:0] IDX_DATA_MASK = 4'h3;
    localparam logic [IDX_W-1:0] IDX_PC0 = 4'h4;
    localparam logic [IDX_W-1:0] IDX_PC_MASK = 4'h8;
    localparam logic [IDX_W-1:0] IDX_LAST = 4'h8;
    localparam logic [WORD_W-1:0] BKPT_RST = 32'h0000_0000;
    localparam logic [PST_W-1:0] PST_HALTED = 4'hf;
    // Serial frame: write flag, register index, data word, MSB first
    localparam int FRAME_BITS = 1 + IDX_W + WORD_W;
    localparam logic [5:0] FRAME_LAST = 6'h24;
    localparam logic [5:0] FRAME_DONE = 6'h25;
    // Trigger source select bit positions
    localparam int SEL_ADDR = 0;
    localparam int SEL_DATA = 1;
    localparam int SEL_PC = 2;

    typedef struct packed {
        logic wr;
        logic [IDX_W-1:0] idx;
        logic [WORD_W-1:0] data;
    } link_req_s;

    typedef struct packed {
        logic [2:0] lvl1_sel;
        logic [2:0] lvl2_sel;
        logic two_level;
        logic halt_sel;
    } trig_cfg_s;

    typedef enum logic [1:0] {TRG_IDLE, TRG_LVL1, TRG_LVL2, TRG_DONE} trig_state_e;
endpackage : dbg_pkg

//--- core_bkpt_trace_dbg.sv
// Breakpoint comparators, triggers, trace port and serial register channel
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1: nine 32-bit breakpoint value and mask registers
// RULE2: registers reachable serially and from supervisor
// RULE3: triggers combine matches, one or two levels
// RULE4: trigger halts or raises debug interrupt
// RULE5: critical interrupts still taken during debug interrupt
// RULE6: status and data trace buses at core rate
// RULE7: halted output is AND of status bits
// RULE8: serial channel, halted output always; trace optional
// RULE9: set mask bit means bit compared
// RULE10: status clock toggles every core cycle
module core_bkpt_trace_dbg (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Serial debug channel, own clock domain
    input wire logic serial_debug_clock_i,
    input wire logic serial_debug_sel_i,
    input wire logic serial_debug_in_i,
    output logic serial_debug_out_o,
    // Supervisor register port
    input wire logic sup_we_i,
    input wire logic [dbg_pkg::IDX_W-1:0] sup_idx_i,
    input wire logic [dbg_pkg::WORD_W-1:0] sup_wdata_i,
    output logic [dbg_pkg::WORD_W-1:0] sup_rdata_o,
    // Core execution observation
    input wire logic cpu_addr_valid_i,
    input wire logic [dbg_pkg::WORD_W-1:0] cpu_addr_i,
    input wire logic cpu_data_valid_i,
    input wire logic [dbg_pkg::WORD_W-1:0] cpu_data_i,
    input wire logic cpu_pc_valid_i,
    input wire logic [dbg_pkg::WORD_W-1:0] cpu_pc_i,
    input wire logic [dbg_pkg::PST_W-1:0] cpu_pst_i,
    input wire logic [dbg_pkg::PST_W-1:0] cpu_trace_data_bus_i,
    // Trigger configuration
    input wire logic trig_arm_i,
    input wire dbg_pkg::trig_cfg_s trig_cfg_i,
    output logic halt_req_o,
    output logic dbg_int_req_o,
    // Interrupt admission during debug interrupt processing
    input wire logic dbg_int_active_i,
    input wire logic int_pending_i,
    input wire logic [2:0] int_level_i,
    input wire logic [2:0] crit_level_i,
    output logic int_allow_o,
    // Trace port
    input wire logic trace_port_en_i,
    output logic [dbg_pkg::PST_W-1:0] proc_status_bus_o,
    output logic [dbg_pkg::PST_W-1:0] trace_data_bus_o,
    output logic status_clock_out_o,
    output logic halted_status_out_o
);
    logic [dbg_pkg::WORD_W-1:0] bkpt_reg [dbg_pkg::REG_CNT];

    // ---------------- Link domain ----------------
    logic [dbg_pkg::FRAME_BITS-2:0] in_shift_reg;
    logic [5:0] bit_cnt_reg;
    logic req_tgl_reg;
    dbg_pkg::link_req_s req_word_reg;
    logic [dbg_pkg::WORD_W-1:0] out_shift_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic ack_tgl_reg;
    logic [dbg_pkg::WORD_W-1:0] rd_hold_reg;
    logic link_idle;

    assign link_idle = (ack_s2_reg == req_tgl_reg);

    always_ff @(posedge serial_debug_clock_i or posedge reset_i) begin
        if (reset_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= ack_tgl_reg;
            ack_s2_reg <= ack_s1_reg;
        end
    end

    // A frame that completes while the previous one is still in flight is dropped
    always_ff @(posedge serial_debug_clock_i or posedge reset_i) begin
        if (reset_i) begin
            in_shift_reg <= '0;
            bit_cnt_reg <= 6'h00;
            req_tgl_reg <= 1'b0;
            req_word_reg <= '0;
        end else if (!serial_debug_sel_i) begin
            bit_cnt_reg <= 6'h00;
        end else if (bit_cnt_reg != dbg_pkg::FRAME_DONE) begin
            in_shift_reg <= {in_shift_reg[dbg_pkg::FRAME_BITS-3:0], serial_debug_in_i};
            bit_cnt_reg <= bit_cnt_reg + 6'h01;
            if (bit_cnt_reg == dbg_pkg::FRAME_LAST && link_idle) begin // RULE2
                req_word_reg <= {in_shift_reg, serial_debug_in_i};
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    // Read data is only sampled when idle, so rd_hold_reg is quiet across the crossing
    always_ff @(posedge serial_debug_clock_i or posedge reset_i) begin
        if (reset_i) begin
            out_shift_reg <= '0;
        end else if (serial_debug_sel_i && bit_cnt_reg == 6'h00 && link_idle) begin
            out_shift_reg <= rd_hold_reg;
        end else if (serial_debug_sel_i) begin
            out_shift_reg <= {out_shift_reg[dbg_pkg::WORD_W-2:0], 1'b0};
        end
    end

    assign serial_debug_out_o = out_shift_reg[dbg_pkg::WORD_W-1]; // RULE8

    // ---------------- Core domain: crossing and buffer ----------------
    logic req_s1_reg;
    logic req_s2_reg;
    logic req_s3_reg;
    logic pending_reg;
    dbg_pkg::link_req_s buf_mem_reg [2];
    logic buf_wr_ptr_reg;
    logic buf_rd_ptr_reg;
    logic [1:0] buf_cnt_reg;
    logic buf_in_ready;
    logic buf_out_valid;
    logic buf_out_ready;
    logic buf_push;
    logic buf_pop;
    dbg_pkg::link_req_s buf_head;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_s3_reg <= 1'b0;
        end else begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            req_s3_reg <= req_s2_reg;
        end
    end

    assign buf_in_ready = (buf_cnt_reg != 2'h2);
    assign buf_out_valid = (buf_cnt_reg != 2'h0);
    // Supervisor writes win the register file; the buffer stalls meanwhile
    assign buf_out_ready = !sup_we_i;
    assign buf_push = pending_reg && buf_in_ready;
    assign buf_pop = buf_out_valid && buf_out_ready;
    assign buf_head = buf_mem_reg[buf_rd_ptr_reg];

    // Set wins over clear when a new request lands on the accept cycle
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pending_reg <= 1'b0;
        end else if (req_s2_reg != req_s3_reg) begin
            pending_reg <= 1'b1;
        end else if (buf_push) begin
            pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            buf_mem_reg[0] <= '0;
            buf_mem_reg[1] <= '0;
            buf_wr_ptr_reg <= 1'b0;
            buf_rd_ptr_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
        end else begin
            if (buf_push) begin
                buf_mem_reg[buf_wr_ptr_reg] <= req_word_reg;
                buf_wr_ptr_reg <= ~buf_wr_ptr_reg;
            end
            if (buf_pop) begin
                buf_rd_ptr_reg <= ~buf_rd_ptr_reg;
            end
            buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    // ---------------- Register file ----------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < dbg_pkg::REG_CNT; i++) begin
                bkpt_reg[i] <= dbg_pkg::BKPT_RST;
            end
        end else if (sup_we_i && sup_idx_i <= dbg_pkg::IDX_LAST) begin
            bkpt_reg[sup_idx_i] <= sup_wdata_i; // RULE1 RULE2
        end else if (buf_pop && buf_head.wr && buf_head.idx <= dbg_pkg::IDX_LAST) begin
            bkpt_reg[buf_head.idx] <= buf_head.data; // RULE2
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_hold_reg <= '0;
            ack_tgl_reg <= 1'b0;
        end else if (buf_pop) begin
            if (!buf_head.wr) begin
                rd_hold_reg <= (buf_head.idx <= dbg_pkg::IDX_LAST) ? bkpt_reg[buf_head.idx] : '0;
            end
            ack_tgl_reg <= ~ack_tgl_reg;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sup_rdata_o <= '0;
        end else begin
            sup_rdata_o <= (sup_idx_i <= dbg_pkg::IDX_LAST) ? bkpt_reg[sup_idx_i] : '0;
        end
    end

    // ---------------- Comparators and triggers ----------------
    logic addr_hit;
    logic data_hit;
    logic [dbg_pkg::PC_CNT-1:0] pc_hits;
    logic [2:0] hits;
    logic cond1;
    logic cond2;
    dbg_pkg::trig_state_e trig_state_reg;

    assign addr_hit = cpu_addr_valid_i &&
        (((cpu_addr_i ^ bkpt_reg[dbg_pkg::IDX_ADDR]) & bkpt_reg[dbg_pkg::IDX_ADDR_MASK]) == '0); // RULE9
    assign data_hit = cpu_data_valid_i &&
        (((cpu_data_i ^ bkpt_reg[dbg_pkg::IDX_DATA]) & bkpt_reg[dbg_pkg::IDX_DATA_MASK]) == '0); // RULE9

    for (genvar g = 0; g < dbg_pkg::PC_CNT; g++) begin : g_pc
        assign pc_hits[g] = cpu_pc_valid_i &&
            (((cpu_pc_i ^ bkpt_reg[dbg_pkg::IDX_PC0 + g]) & bkpt_reg[dbg_pkg::IDX_PC_MASK]) == '0);
    end

    assign hits = {|pc_hits, data_hit, addr_hit};

    // All selected sources must hit; an empty selection never fires
    function automatic logic cond_met(input logic [2:0] sel, input logic [2:0] hv);
        cond_met = (|sel) && ((sel & hv) == sel);
    endfunction : cond_met

    assign cond1 = cond_met(trig_cfg_i.lvl1_sel, hits); // RULE3
    assign cond2 = cond_met(trig_cfg_i.lvl2_sel, hits); // RULE3

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            trig_state_reg <= dbg_pkg::TRG_IDLE;
            halt_req_o <= 1'b0;
            dbg_int_req_o <= 1'b0;
        end else begin
            halt_req_o <= 1'b0;
            dbg_int_req_o <= 1'b0;
            case (trig_state_reg)
                dbg_pkg::TRG_IDLE: begin
                    if (trig_arm_i) begin
                        trig_state_reg <= dbg_pkg::TRG_LVL1;
                    end
                end
                dbg_pkg::TRG_LVL1: begin
                    if (!trig_arm_i) begin
                        trig_state_reg <= dbg_pkg::TRG_IDLE;
                    end else if (cond1 && trig_cfg_i.two_level) begin
                        trig_state_reg <= dbg_pkg::TRG_LVL2; // RULE3
                    end else if (cond1) begin
                        trig_state_reg <= dbg_pkg::TRG_DONE;
                        halt_req_o <= trig_cfg_i.halt_sel; // RULE4
                        dbg_int_req_o <= !trig_cfg_i.halt_sel; // RULE4
                    end
                end
                dbg_pkg::TRG_LVL2: begin
                    if (!trig_arm_i) begin
                        trig_state_reg <= dbg_pkg::TRG_IDLE;
                    end else if (cond2) begin
                        trig_state_reg <= dbg_pkg::TRG_DONE;
                        halt_req_o <= trig_cfg_i.halt_sel; // RULE4
                        dbg_int_req_o <= !trig_cfg_i.halt_sel; // RULE4
                    end
                end
                dbg_pkg::TRG_DONE: begin
                    if (!trig_arm_i) begin
                        trig_state_reg <= dbg_pkg::TRG_IDLE;
                    end
                end
                default: trig_state_reg <= dbg_pkg::TRG_IDLE;
            endcase
        end
    end

    // Interrupts at or above the critical level bypass the debug interrupt hold-off
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            int_allow_o <= 1'b0;
        end else begin
            int_allow_o <= int_pending_i && (!dbg_int_active_i || int_level_i >= crit_level_i); // RULE5
        end
    end

    // ---------------- Trace port ----------------
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            proc_status_bus_o <= '0;
            trace_data_bus_o <= '0;
            status_clock_out_o <= 1'b0;
        end else if (trace_port_en_i) begin
            proc_status_bus_o <= cpu_pst_i; // RULE6
            trace_data_bus_o <= cpu_trace_data_bus_i; // RULE6
            status_clock_out_o <= ~status_clock_out_o; // RULE10
        end else begin
            proc_status_bus_o <= '0; // RULE8
            trace_data_bus_o <= '0;
            status_clock_out_o <= 1'b0;
        end
    end

    // Halted detect stays alive even with the trace port disabled
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            halted_status_out_o <= 1'b0;
        end else begin
            halted_status_out_o <= (cpu_pst_i == dbg_pkg::PST_HALTED); // RULE7 RULE8
        end
    end

    // ---------------- Assertions ----------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    sequence seq_single_hit;
        trig_state_reg == dbg_pkg::TRG_LVL1 && trig_arm_i && cond1 && !trig_cfg_i.two_level;
    endsequence
    sequence seq_fire;
        halt_req_o || dbg_int_req_o;
    endsequence

    AST_SINGLE_FIRE: assert property (seq_single_hit |=> seq_fire) // RULE3
        else $error("single-level trigger did not fire");
    AST_FIRE_KIND: assert property (seq_fire |-> halt_req_o == $past(trig_cfg_i.halt_sel)) // RULE4
        else $error("trigger action does not follow selection");
    AST_FIRE_ONE: assert property (!(halt_req_o && dbg_int_req_o)) // RULE4
        else $error("halt and debug interrupt raised together");
    AST_CRIT_INT: assert property (dbg_int_active_i && int_pending_i &&
        int_level_i >= crit_level_i |=> int_allow_o) // RULE5
        else $error("critical interrupt blocked during debug");
    AST_PST_FOLLOW: assert property (trace_port_en_i |=> proc_status_bus_o == $past(cpu_pst_i)) // RULE6
        else $error("status bus does not follow core");
    AST_HALTED: assert property (halted_status_out_o == (proc_status_bus_o == dbg_pkg::PST_HALTED)
        || !$past(trace_port_en_i)) // RULE7
        else $error("halted output differs from AND of status");
    AST_TRACE_OFF: assert property (!trace_port_en_i |=> proc_status_bus_o == '0 && !status_clock_out_o) // RULE8
        else $error("trace port driven while disabled");
    AST_STCLK: assert property (trace_port_en_i ##1 trace_port_en_i |->
        status_clock_out_o != $past(status_clock_out_o)) // RULE10
        else $error("status clock missed a toggle");
    AST_SUP_WR: assert property (sup_we_i && sup_idx_i == dbg_pkg::IDX_ADDR |=>
        bkpt_reg[0] == $past(sup_wdata_i)) // RULE2
        else $error("supervisor write lost");
    AST_MASK_OPEN: assert property (bkpt_reg[dbg_pkg::IDX_ADDR_MASK] == '0 |->
        addr_hit == cpu_addr_valid_i) // RULE9
        else $error("zero mask did not match everything");
endmodule : core_bkpt_trace_dbg
`default_nettype wire

//--- dbg_tool_model.sv
// Behavioural model of the external debug tool on the serial channel
`timescale 1ns/1ns
`default_nettype none
module dbg_tool_model (
    output logic link_clk_o,
    output logic sel_o,
    output logic din_o,
    input wire logic dout_i
);
    initial begin
        link_clk_o = 1'b0;
        sel_o = 1'b0;
        din_o = 1'b0;
    end
    // Clock stands still unless the tool runs a frame or an idle gap
    task automatic idle(input int n);
        repeat (n) begin
            #7 link_clk_o = 1'b1;
            #8 link_clk_o = 1'b0;
        end
    endtask : idle
    // Write flag, index, word, MSB first; returns the word shifted out meanwhile
    task automatic frame(input logic wr, input logic [3:0] idx, input logic [31:0] data,
                         output logic [31:0] rd);
        logic [dbg_pkg::FRAME_BITS-1:0] bits;
        bits = {wr, idx, data};
        rd = 32'h0;
        sel_o = 1'b1;
        for (int i = 0; i < dbg_pkg::FRAME_BITS; i++) begin
            din_o = bits[dbg_pkg::FRAME_BITS-1-i];
            if (i >= 1 && i <= 32) rd[32-i] = dout_i;
            #7 link_clk_o = 1'b1;
            #8 link_clk_o = 1'b0;
        end
        sel_o = 1'b0;
        // Released line shows the inverse so a stale bit is never mistaken for data
        din_o = ~din_o;
        // Gap lets the core apply the frame and the acknowledge cross back
        idle(8);
    endtask : frame
endmodule : dbg_tool_model
`default_nettype wire

//--- core_bkpt_trace_dbg_bench.sv
// Self-checking bench for the breakpoint, trigger and trace debug block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, o) begin check_count++; if ((o) !== (e)) begin n_errors++; \
    $display("mismatch %s expected %h seen %h", nm, e, o); end end
module core_bkpt_trace_dbg_bench;
    logic sys_clk_i = 1'b0;
    logic reset_i = 1'b1;
    wire link_clk;
    wire link_sel;
    wire link_din;
    wire link_dout;
    logic sup_we = 1'b0, av = 1'b0, dv = 1'b0, pv = 1'b0, arm = 1'b0, act = 1'b0, pend = 1'b0;
    logic ten = 1'b1, trace_chk = 1'b0, p_en, p_sclk;
    logic halt, dint, allow, sclk, hsto;
    logic [3:0] sup_idx = 4'h0, proc_status_bus = 4'h0, dd = 4'h0, psb, tdb, p_pst, p_dd;
    logic [2:0] lvl = 3'h0, crit = 3'h0;
    logic [1:0] kind = 2'h0;
    logic [31:0] sup_wdata = 32'h0, a = 32'h0, d = 32'h0, pc = 32'h0, sup_rdata, rd, wv;
    logic [31:0] regs [0:9];
    logic [31:0] exp_q [$];
    string name_q [$];
    dbg_pkg::trig_cfg_s cfg = '0;
    int n_errors = 0, check_count = 0, cycles = 0, seed = 32'hf40e;
    localparam logic [31:0] A = 32'h1357_9bdf, D = 32'h2468_ace0, P = 32'h0000_4c80;

    dbg_tool_model tool (.link_clk_o(link_clk), .sel_o(link_sel), .din_o(link_din),
        .dout_i(link_dout));
    core_bkpt_trace_dbg dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
        .serial_debug_clock_i(link_clk), .serial_debug_sel_i(link_sel),
        .serial_debug_in_i(link_din), .serial_debug_out_o(link_dout),
        .sup_we_i(sup_we), .sup_idx_i(sup_idx), .sup_wdata_i(sup_wdata), .sup_rdata_o(sup_rdata),
        .cpu_addr_valid_i(av), .cpu_addr_i(a), .cpu_data_valid_i(dv), .cpu_data_i(d),
        .cpu_pc_valid_i(pv), .cpu_pc_i(pc), .cpu_pst_i(proc_status_bus), .cpu_trace_data_bus_i(dd),
        .trig_arm_i(arm), .trig_cfg_i(cfg), .halt_req_o(halt), .dbg_int_req_o(dint),
        .dbg_int_active_i(act), .int_pending_i(pend), .int_level_i(lvl), .crit_level_i(crit),
        .int_allow_o(allow), .trace_port_en_i(ten), .proc_status_bus_o(psb),
        .trace_data_bus_o(tdb), .status_clock_out_o(sclk), .halted_status_out_o(hsto));

    initial begin
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    task automatic note(input string nm, input logic [31:0] e);
        name_q.push_back(nm);
        exp_q.push_back(e);
    endtask : note

    // Oldest note against a result; a result with no note pending is a spare one
    task automatic seen(input logic [31:0] v);
        string nm;
        logic [31:0] e;
        logic [31:0] o;
        nm = "spare result";
        e = 32'h0;
        // Never zero, even for an unknown result, so a spare one always counts
        o = ~(v ^ v);
        if (exp_q.size() != 0) begin
            nm = name_q.pop_front();
            e = exp_q.pop_front();
            o = v;
        end
        `CHK(nm, e, o)
    endtask : seen

    task automatic sup_wr(input logic [3:0] idx, input logic [31:0] v);
        @(negedge sys_clk_i);
        sup_we = 1'b1;
        sup_idx = idx;
        sup_wdata = v;
        @(negedge sys_clk_i) sup_we = 1'b0;
    endtask : sup_wr

    task automatic sup_rd(input logic [3:0] idx, input logic [31:0] e);
        @(negedge sys_clk_i);
        sup_idx = idx;
        note("sup_rdata", e);
        kind = 2'h1;
        @(negedge sys_clk_i) kind = 2'h0;
    endtask : sup_rd

    task automatic end_test(input string nm);
        $display("test %s done", nm);
    endtask : end_test

    // Output watcher: sees the inputs as sampled at the edge, compares once settled
    always @(posedge sys_clk_i) begin
        p_pst = proc_status_bus;
        p_dd = dd;
        p_en = ten;
        p_sclk = sclk;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
        #2;
        if (halt | dint) seen({30'h0, halt, dint});
        if (kind == 2'h1) seen(sup_rdata);
        if (kind == 2'h2) seen({31'h0, allow});
        if (trace_chk) begin
            `CHK("proc_status_bus", p_en ? p_pst : 4'h0, psb)
            `CHK("trace_data_bus", p_en ? p_dd : 4'h0, tdb)
            `CHK("status_clock_out", p_en ? ~p_sclk : 1'b0, sclk)
            `CHK("halted_status_out", &p_pst, hsto)
        end
    end

    initial begin
        regs[9] = 32'h0;
        fork
            tool.idle(6);
            repeat (16) @(posedge sys_clk_i);
        join
        @(negedge sys_clk_i) reset_i = 1'b0;
        tool.idle(4);
        for (int i = 0; i < 9; i++) sup_rd(4'(i), 32'h0);
        for (int i = 0; i < 9; i++) begin
            regs[i] = $random(seed);
            sup_wr(4'(i), regs[i]);
        end
        sup_wr(4'h9, 32'hdead_beef);
        for (int i = 0; i < 10; i++) sup_rd(4'(i), regs[i]);
        end_test("supervisor registers");
        wv = $random(seed);
        tool.frame(1'b1, 4'h5, wv, rd);
        sup_rd(4'h5, wv);
        tool.frame(1'b0, 4'h5, 32'h0, rd);
        tool.frame(1'b0, 4'h9, 32'h0, rd);
        note("serial read", wv);
        seen(rd);
        tool.frame(1'b0, 4'h0, 32'h0, rd);
        note("serial unmapped read", 32'h0);
        seen(rd);
        end_test("serial channel");
        sup_wr(dbg_pkg::IDX_ADDR, A);
        sup_wr(dbg_pkg::IDX_ADDR_MASK, 32'hffff_0000);
        sup_wr(dbg_pkg::IDX_DATA, D);
        sup_wr(dbg_pkg::IDX_DATA_MASK, 32'hffff_ffff);
        sup_wr(4'h6, P);
        sup_wr(dbg_pkg::IDX_PC_MASK, 32'hffff_ffff);
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk_i);
            cfg = '{lvl1_sel: 3'h5, lvl2_sel: 3'h2, two_level: k[1], halt_sel: k[0]};
            arm = 1'b1;
            av = 1'b1;
            pv = 1'b1;
            pc = P;
            a = A ^ 32'h8000_0000;
            repeat (3) @(negedge sys_clk_i);
            // Held for three cycles: only the first may fire, one fire per arm
            a = A ^ 32'h0000_1234;
            if (k < 2) note("trigger", {30'h0, k[0], ~k[0]});
            repeat (3) @(negedge sys_clk_i);
            a = ~A;
            if (k >= 2) begin
                dv = 1'b1;
                d = D ^ 32'h1;
                repeat (2) @(negedge sys_clk_i);
                d = D;
                note("two level trigger", {30'h0, k[0], ~k[0]});
                @(negedge sys_clk_i) dv = 1'b0;
            end
            repeat (3) @(negedge sys_clk_i);
            arm = 1'b0;
        end
        end_test("triggers");
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk_i);
            {act, pend, lvl, crit} = 8'($random(seed));
            note("int_allow", {31'h0, pend & (~act | (lvl >= crit))});
            kind = 2'h2;
        end
        @(negedge sys_clk_i) kind = 2'h0;
        end_test("interrupt admission");
        trace_chk = 1'b1;
        for (int i = 0; i < 60; i++) begin
            @(negedge sys_clk_i);
            {proc_status_bus, dd} = 8'($random(seed));
            if (i % 4 == 0) proc_status_bus = dbg_pkg::PST_HALTED;
            ten = (i < 30) || (i >= 45);
        end
        @(negedge sys_clk_i) trace_chk = 1'b0;
        end_test("trace port");
        repeat (4) @(negedge sys_clk_i);
        // A trigger that never fired leaves its note behind
        `CHK("notes left", 32'h0, 32'(exp_q.size()))
        complete_run();
    end
endmodule : core_bkpt_trace_dbg_bench
`undef CHK
`default_nettype wire
